// File: hdl/peiu_phy_event_irq.sv
/*
 * Event interrupt unit of the transceiver: eight latched source flags,
 * their enable mask, primary and alternate clearing modes, the late
 * energy-detect pulse and routing of the active-low line to three pins.
 * Assumes the management frame engine presents decoded register accesses
 * as one-cycle strobes on mclk, and that all status inputs come from
 * logic already on mclk, so none of them is synchronised here.
 * The wake pin, the indicator drivers and the mode select bit itself
 * live outside this unit and only meet it through the ports below.
 */
`timescale 1ns/10ps
`default_nettype none

module peiu_phy_event_irq #(
    parameter int DELAY_CYC = peiu_pkg::ENERGY_DELAY_CYC,
    parameter int PULSE_CYC = peiu_pkg::ENERGY_PULSE_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    output var  logic [15:0] reg_rdata,
    input  wire logic        alt_irq_mode_sel,
    input  wire logic [1:0]  irq_route_sel,
    input  wire logic [3:0]  wake_status,
    input  wire logic        line_energy_detect,
    input  wire logic        an_complete,
    input  wire logic        remote_fault,
    input  wire logic        link_status,
    input  wire logic        lp_acknowledge,
    input  wire logic        par_detect_fault,
    input  wire logic        page_received,
    input  wire logic        an_restart,
    output var  logic        irq_out_n,
    output var  logic        irq_tx_error_pin_n,
    output var  logic        irq_ind1_pin_n,
    output var  logic        irq_ind2_pin_n
);
    import peiu_pkg::*;

    // Terminal counts of the late-pulse timer. One counter serves both the
    // wait and the pulse, so both counts must fit in TIMER_W bits; the
    // default one-second wait is the larger of the two.
    localparam logic [TIMER_W-1:0] DELAY_LAST = TIMER_W'(DELAY_CYC - 1);
    localparam logic [TIMER_W-1:0] PULSE_LAST = TIMER_W'(PULSE_CYC - 1);
    localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;

    // Register copies, last-seen source levels and per-event set and
    // clear terms. Event vectors are indexed by the flag bit positions,
    // so bit i of every vector belongs to the same event.
    logic [15:0]        flags;
    logic [15:0]        next_flags;
    logic [15:0]        mask;
    logic [15:0]        next_mask;
    logic [15:0]        next_rdata;
    logic [EV_HI:EV_LO] active;
    logic [EV_HI:EV_LO] active_prev;
    logic [EV_HI:EV_LO] rise;
    logic [EV_HI:EV_LO] fall;
    logic [EV_HI:EV_LO] set_ev;
    logic [EV_HI:EV_LO] clr_ev;
    logic               rd_flags;
    logic               rd_status;
    logic               rd_expansion;
    logic               wr_flags;
    logic               wr_mask;
    logic               link_lost;
    peiu_late_e         late_state;
    peiu_late_e         next_late_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic               late_pulse;
    logic               next_irq_n;
    logic               next_tx_error_n;
    logic               next_ind1_n;
    logic               next_ind2_n;

    // Each event as an active-high level; link down is link status low.
    // Turning link loss into a rising level lets one edge detector serve
    // all eight events alike.
    assign active[EV_WAKE]         = |wake_status;
    assign active[EV_ENERGY]       = line_energy_detect;
    assign active[EV_AN_DONE]      = an_complete;
    assign active[EV_REMOTE_FAULT] = remote_fault;
    assign active[EV_LINK_DOWN]    = ~link_status;
    assign active[EV_LP_ACK]       = lp_acknowledge;
    assign active[EV_PAR_FAULT]    = par_detect_fault;
    assign active[EV_PAGE_RX]      = page_received;

    // Decoded register strobes. Reads of the basic status and expansion
    // registers are only watched here: their data comes from elsewhere,
    // but in primary mode each such read releases some of the flags below.
    assign rd_flags     = reg_rd && (reg_addr == REG_SRC_FLAGS);
    assign rd_status    = reg_rd && (reg_addr == REG_BASIC_STATUS);
    assign rd_expansion = reg_rd && (reg_addr == REG_AN_EXPANSION);
    assign wr_flags     = reg_wr && (reg_addr == REG_SRC_FLAGS);
    assign wr_mask      = reg_wr && (reg_addr == REG_IRQ_MASK);
    assign rise         = active & ~active_prev;
    assign fall         = ~active & active_prev;
    assign link_lost    = rise[EV_LINK_DOWN];

    // Per-event set and clear terms. Setting always beats clearing, so an
    // edge landing on the same cycle as a read or a write-one survives.
    // Reads never clear in alternate mode and write-one never clears in
    // primary mode; the mode input picks one of the two terms per event.
    generate
        for (genvar i = EV_LO; i <= EV_HI; i++) begin : g_event
            logic prim_clr;
            logic alt_clr;
            always_comb begin
                // Link down has no edge clear: only reads release it.
                prim_clr = rd_flags
                    || ((i != EV_LINK_DOWN) && fall[i]);
                if (i == EV_WAKE) begin
                    prim_clr = rd_flags || !active[i];
                end
                if (i == EV_REMOTE_FAULT || i == EV_LINK_DOWN) begin
                    prim_clr = prim_clr || rd_status;
                end
                if (i == EV_PAR_FAULT || i == EV_PAGE_RX) begin
                    prim_clr = prim_clr || rd_expansion
                        || an_restart || link_lost;
                end
                // Write-one only clears if the source has gone quiet.
                alt_clr = wr_flags && reg_wdata[i]
                    && !active[i];
            end
            // Only a fresh edge sets a flag; a level left standing does not.
            assign set_ev[i] = rise[i];
            assign clr_ev[i] = alt_irq_mode_sel ? alt_clr : prim_clr;
        end
    endgenerate

    // Next register contents and registered read data. Read data is zero
    // outside the cycle after a read, so a stale word never lingers on the
    // shared return path; unused bits always read as zero.
    always_comb begin
        next_flags = flags;
        next_mask  = mask;
        for (int k = EV_LO; k <= EV_HI; k++) begin
            if (set_ev[k]) begin
                next_flags[k] = 1'b1;
            end else if (clr_ev[k]) begin
                next_flags[k] = 1'b0;
            end
        end
        if (wr_mask) begin
            next_mask = reg_wdata & EV_FIELD;
        end
        next_rdata = DATA_ZERO;
        if (rd_flags) begin
            next_rdata = flags & EV_FIELD;
        end else if (reg_rd && (reg_addr == REG_IRQ_MASK)) begin
            next_rdata = mask & EV_FIELD;
        end
    end

    // Register state. Flags start with the energy bit set.
    // The last-seen energy level also resets high, as acquisition starts
    // with energy present; if the line is quiet, the first cycle after
    // reset sees a falling edge and, in primary mode, the energy flag drops by itself.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags       <= FLAGS_RESET;
            mask        <= MASK_RESET;
            reg_rdata   <= DATA_ZERO;
            active_prev <= FLAGS_RESET[EV_HI:EV_LO];
        end else begin
            flags       <= next_flags;
            mask        <= next_mask;
            reg_rdata   <= next_rdata;
            active_prev <= active;
        end
    end

    // Late energy pulse: arms when the energy flag is cleared with energy
    // still high, then fires a fixed pulse a second after energy drops.
    // The pulse bypasses the flag, which is why software should drop the
    // mask in its handler; dropping the mask also disarms it here.
    always_comb begin
        next_late_state = late_state;
        next_timer      = timer;
        if (!mask[EV_ENERGY]) begin
            next_late_state = PEIU_LATE_IDLE;
            next_timer      = TIMER_ZERO;
        end else begin
            case (late_state)
                // Idle: arm only on a flag cleared with energy still up.
                PEIU_LATE_IDLE: begin
                    if (flags[EV_ENERGY] && !next_flags[EV_ENERGY]
                        && active[EV_ENERGY]) begin
                        next_late_state = PEIU_LATE_ARMED;
                    end
                end
                // Armed: wait for energy to leave the line.
                PEIU_LATE_ARMED: begin
                    if (fall[EV_ENERGY]) begin
                        next_late_state = PEIU_LATE_WAIT;
                        next_timer      = TIMER_ZERO;
                    end
                end
                // Counts the delay from the fall of energy.
                PEIU_LATE_WAIT: begin
                    next_timer = timer + 1'b1;
                    if (timer == DELAY_LAST) begin
                        next_late_state = PEIU_LATE_PULSE;
                        next_timer      = TIMER_ZERO;
                    end
                end
                // Holds the line low for the fixed pulse length.
                PEIU_LATE_PULSE: begin
                    next_timer = timer + 1'b1;
                    if (timer == PULSE_LAST) begin
                        next_late_state = PEIU_LATE_IDLE;
                        next_timer      = TIMER_ZERO;
                    end
                end
                default: begin
                    next_late_state = PEIU_LATE_IDLE;
                    next_timer      = TIMER_ZERO;
                end
            endcase
        end
    end

    // Late-pulse state and timer registers. Reset leaves the timer idle,
    // so a pulse can never be half-way through when the unit comes up.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            late_state <= PEIU_LATE_IDLE;
            timer      <= TIMER_ZERO;
        end else begin
            late_state <= next_late_state;
            timer      <= next_timer;
        end
    end

    // The pulse is a plain state decode; it reaches the pins through the
    // output flip-flops, one cycle after the state enters the pulse.
    assign late_pulse = (late_state == PEIU_LATE_PULSE);

    // Line level and pin routing. The line follows the flags with one
    // register stage so every pin comes straight from a flip-flop; the
    // unselected pins idle high. Route value three is unused and falls
    // back to the transmit-error pin, so a bad strap never hides the line.
    // Changing the route moves the line on the next cycle, not mid-cycle.
    always_comb begin
        next_irq_n  = ~(|(next_flags[EV_HI:EV_LO] & next_mask[EV_HI:EV_LO])
                        || late_pulse);
        next_tx_error_n = 1'b1;
        next_ind1_n = 1'b1;
        next_ind2_n = 1'b1;
        case (irq_route_sel)
            ROUTE_TX_ERROR_PIN: next_tx_error_n = next_irq_n;
            ROUTE_IND1_PIN: next_ind1_n = next_irq_n;
            ROUTE_IND2_PIN: next_ind2_n = next_irq_n;
            default:        next_tx_error_n = next_irq_n;
        endcase
    end

    // Output flip-flops. All pins reset high, so no interrupt is seen
    // while the unit is held in reset.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_out_n      <= 1'b1;
            irq_tx_error_pin_n <= 1'b1;
            irq_ind1_pin_n <= 1'b1;
            irq_ind2_pin_n <= 1'b1;
        end else begin
            irq_out_n      <= next_irq_n;
            irq_tx_error_pin_n <= next_tx_error_n;
            irq_ind1_pin_n <= next_ind1_n;
            irq_ind2_pin_n <= next_ind2_n;
        end
    end

endmodule : peiu_phy_event_irq

`default_nettype wire

// File: hdl/peiu_pkg.sv
/*
 * Shared constants for the transceiver event interrupt unit: register
 * addresses, field positions, reset values, pin routes and timing.
 * Assumes a single 125 MHz device clock drives the whole unit.
 */
package peiu_pkg;

    // Management register addresses seen on the internal register port.
    localparam logic [4:0]  REG_BASIC_STATUS = 5'h01;
    localparam logic [4:0]  REG_AN_EXPANSION = 5'h06;
    localparam logic [4:0]  REG_SRC_FLAGS    = 5'h1d;
    localparam logic [4:0]  REG_IRQ_MASK     = 5'h1e;

    // Event positions inside the flag and mask registers.
    localparam int          EV_LO            = 1;
    localparam int          EV_HI            = 8;
    localparam int          EV_PAGE_RX       = 1;
    localparam int          EV_PAR_FAULT     = 2;
    localparam int          EV_LP_ACK        = 3;
    localparam int          EV_LINK_DOWN     = 4;
    localparam int          EV_REMOTE_FAULT  = 5;
    localparam int          EV_AN_DONE       = 6;
    localparam int          EV_ENERGY        = 7;
    localparam int          EV_WAKE          = 8;

    // Reset values; the energy flag starts set because acquisition does.
    localparam logic [15:0] FLAGS_RESET      = 16'h0080;
    localparam logic [15:0] MASK_RESET       = 16'h0000;
    localparam logic [15:0] EV_FIELD         = 16'h01fe;
    localparam logic [15:0] DATA_ZERO        = 16'h0000;

    // Output pin routes for the interrupt line.
    localparam logic [1:0]  ROUTE_TX_ERROR_PIN   = 2'h0;
    localparam logic [1:0]  ROUTE_IND1_PIN   = 2'h1;
    localparam logic [1:0]  ROUTE_IND2_PIN   = 2'h2;

    // Late energy-detect pulse timing.
    localparam int          CLK_HZ           = 125_000_000;
    localparam int          ENERGY_DELAY_MS  = 1000;
    localparam int          ENERGY_PULSE_MS  = 256;
    localparam int          ENERGY_DELAY_CYC = CLK_HZ / 1000 * ENERGY_DELAY_MS;
    localparam int          ENERGY_PULSE_CYC = CLK_HZ / 1000 * ENERGY_PULSE_MS;
    localparam int          TIMER_W          = 27;

    typedef enum logic [1:0] {
        PEIU_LATE_IDLE,
        PEIU_LATE_ARMED,
        PEIU_LATE_WAIT,
        PEIU_LATE_PULSE
    } peiu_late_e;

endpackage : peiu_pkg

// File: dv/peiu_irq_chk.sv
/*
 * Checker for the event interrupt unit, bound to its top module.
 * Assumes one mclk domain and one-cycle register strobes.
 */
`timescale 1ns/10ps
`default_nettype none

module peiu_irq_chk (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [4:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        alt_irq_mode_sel,
    input wire logic [1:0]  irq_route_sel,
    input wire logic        an_complete,
    input wire logic        link_status,
    input wire logic        irq_out_n,
    input wire logic        irq_ind1_pin_n
);
    import peiu_pkg::*;

    logic [15:0] mask_sh;
    logic [15:0] next_mask_sh;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Shadow of the mask, since the unit's own copy is out of sight.
    always_comb begin
        next_mask_sh = mask_sh;
        if (reg_wr && reg_addr == REG_IRQ_MASK)
            next_mask_sh = reg_wdata & EV_FIELD;
    end

    // Registered shadow, reset as the unit's mask is.
    always_ff @(posedge mclk) begin
        if (!rst_n)
            mask_sh <= MASK_RESET;
        else
            mask_sh <= next_mask_sh;
    end

    // Line quiet at release; read data only in the cycle after a read.
    AST_RST_IDLE: assert property ($rose(rst_n) |-> irq_out_n)
        else $error("line low after reset");
    AST_RD_STANDS: assert property (
        !$past(reg_rd) |-> reg_rdata == DATA_ZERO)
        else $error("read data outside its cycle");
    AST_MASK_RD: assert property (
        reg_rd && reg_addr == REG_IRQ_MASK |=> reg_rdata == $past(mask_sh))
        else $error("mask read back wrong");
    // Two cycles of an empty mask leave the line high, whatever is latched.
    AST_MASK_OFF: assert property (
        (mask_sh == DATA_ZERO) [*2] |-> irq_out_n)
        else $error("line low with empty mask");
    AST_LINK_DOWN: assert property (
        mask_sh[EV_LINK_DOWN] && $fell(link_status) |=> !irq_out_n)
        else $error("link loss not signalled");
    AST_AN_RISE: assert property (
        mask_sh[EV_AN_DONE] && $rose(an_complete) |=> !irq_out_n)
        else $error("negotiation done not signalled");
    // Write-one with the source still active must not release the line.
    AST_ALT_HOLD: assert property (
        alt_irq_mode_sel && reg_wr && reg_addr == REG_SRC_FLAGS &&
        reg_wdata[EV_AN_DONE] && an_complete && !irq_out_n &&
        mask_sh == 16'h0040 |=> !irq_out_n)
        else $error("flag cleared with source active");
    AST_ROUTE_IND1: assert property (
        $stable(irq_route_sel) && $stable(irq_out_n) |-> irq_ind1_pin_n ==
        ((irq_route_sel == ROUTE_IND1_PIN) ? irq_out_n : 1'b1))
        else $error("indicator 1 pin routing wrong");
endmodule : peiu_irq_chk

bind peiu_phy_event_irq peiu_irq_chk i_peiu_irq_chk (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .alt_irq_mode_sel(alt_irq_mode_sel), .irq_route_sel(irq_route_sel),
    .an_complete(an_complete), .link_status(link_status),
    .irq_out_n(irq_out_n), .irq_ind1_pin_n(irq_ind1_pin_n)
);
`default_nettype wire

// File: dv/peiu_host_model.sv
/*
 * Host station model: management reads and writes on the decoded port.
 * Assumes the unit answers a read in the cycle after its strobe.
 */
`timescale 1ns/10ps
`default_nettype none

module peiu_host_model (
    input  wire logic        mclk,
    input  wire logic [15:0] reg_rdata,
    output var  logic [4:0]  reg_addr,
    output var  logic        reg_rd,
    output var  logic        reg_wr,
    output var  logic [15:0] reg_wdata
);
    // Idle; released lines show inverted values so stale data never helps.
    initial begin
        reg_addr = 5'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
    end

    // One write, strobe held over a single edge.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // One read; the answer stands only in the following cycle.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : peiu_host_model
`default_nettype wire

// File: dv/peiu_phy_event_irq_tb.sv
/*
 * Self-checking bench for the event interrupt unit: drives status levels
 * and reaches the registers through the host model.
 * Assumes short late-pulse counts so the run stays brief.
 */
`timescale 1ns/10ps
`default_nettype none

module peiu_phy_event_irq_tb;
    import peiu_pkg::*;
    localparam int DLY = 20;
    localparam int PLS = 8;
    logic        mclk, rst_n, alt_irq_mode_sel, line_energy_detect;
    logic        an_complete, remote_fault, link_status, lp_acknowledge;
    logic        par_detect_fault, page_received, an_restart, reg_rd;
    logic        reg_wr, irq_out_n, irq_tx_error_pin_n, irq_ind1_pin_n;
    logic        irq_ind2_pin_n;
    logic [1:0]  irq_route_sel;
    logic [3:0]  wake_status;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rv;
    int          n_fail, n_compared, cnt;
    int          ord[8] = '{1, 2, 3, 4, 5, 6, 8, 7};
    logic [4:0]  clr[9] = '{5'h00, REG_AN_EXPANSION, REG_AN_EXPANSION,
        REG_SRC_FLAGS, REG_BASIC_STATUS, REG_BASIC_STATUS, REG_SRC_FLAGS,
        REG_SRC_FLAGS, REG_SRC_FLAGS};

    peiu_phy_event_irq #(.DELAY_CYC(DLY), .PULSE_CYC(PLS))
        i_peiu_phy_event_irq (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .alt_irq_mode_sel(alt_irq_mode_sel), .irq_route_sel(irq_route_sel),
        .wake_status(wake_status), .line_energy_detect(line_energy_detect),
        .an_complete(an_complete), .remote_fault(remote_fault),
        .link_status(link_status), .lp_acknowledge(lp_acknowledge),
        .par_detect_fault(par_detect_fault), .page_received(page_received),
        .an_restart(an_restart), .irq_out_n(irq_out_n),
        .irq_tx_error_pin_n(irq_tx_error_pin_n), .irq_ind1_pin_n(irq_ind1_pin_n),
        .irq_ind2_pin_n(irq_ind2_pin_n));
    peiu_host_model i_peiu_host_model (.mclk(mclk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata));

    // Free-running 125 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Compare, report a mismatch at once, count both.
    task automatic chk(input logic [15:0] g, input logic [15:0] e, string s);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %0t %s got %h want %h", $time, s, g, e);
        end
    endtask : chk

    task automatic rd(input logic [4:0] a);
        i_peiu_host_model.rd(a, rv);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        i_peiu_host_model.wr(a, d);
    endtask : wr

    // Line level after one more edge, so the event edge has landed.
    task automatic irq(input logic e);
        @(posedge mclk);
        #1;
        chk({15'h0, irq_out_n}, {15'h0, e}, "line");
    endtask : irq

    // Drive one event source active or inactive; link down is link low.
    task automatic set_ev(input int i, input logic v);
        @(posedge mclk);
        #1;
        case (i)
            1: page_received = v;
            2: par_detect_fault = v;
            3: lp_acknowledge = v;
            4: link_status = !v;
            5: remote_fault = v;
            6: an_complete = v;
            7: line_energy_detect = v;
            default: wake_status = {v, 3'h0};
        endcase
    endtask : set_ev

    // Cycles the line holds a level; the bound turns a hang into a miss.
    task automatic hold(input logic v, output int n);
        n = 0;
        while (irq_out_n === v && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask : hold

    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // Main sequence; energy starts high as acquisition does.
    initial begin
        {n_fail, n_compared, an_restart, alt_irq_mode_sel} = '0;
        {an_complete, remote_fault, lp_acknowledge} = '0;
        {par_detect_fault, page_received, irq_route_sel, wake_status} = '0;
        {rst_n, line_energy_detect, link_status} = 3'b011;
        repeat (12) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        rd(REG_SRC_FLAGS);
        chk(rv, FLAGS_RESET, "flags");
        rd(REG_IRQ_MASK);
        chk(rv, MASK_RESET, "mask");
        // Reset again mid-run, then lose energy: the flag must drop alone.
        @(posedge mclk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        set_ev(7, 1'b0);
        rd(REG_SRC_FLAGS);
        chk(rv, DATA_ZERO, "flags");
        $display("test reset done");
        // Each event alone, cleared by its own register read.
        foreach (ord[k]) begin
            wr(REG_IRQ_MASK, 16'h1 << ord[k]);
            set_ev(ord[k], 1'b1);
            irq(1'b0);
            rd(clr[ord[k]]);
            chk(rv, (clr[ord[k]] == REG_SRC_FLAGS) ? 16'h1 << ord[k] : 16'h0,
                "src");
            irq(1'b1);
            rd(REG_SRC_FLAGS);
            chk(rv, DATA_ZERO, "flags");
            if (ord[k] != 7)
                set_ev(ord[k], 1'b0);
        end
        // Energy flag was cleared while high: a late pulse follows its fall.
        set_ev(7, 1'b0);
        hold(1'b1, cnt);
        chk(16'(cnt >= DLY - 1 && cnt <= DLY + 3), 16'h1, "delay");
        hold(1'b0, cnt);
        chk(16'(cnt >= PLS - 1 && cnt <= PLS + 1), 16'h1, "pulse");
        wr(REG_IRQ_MASK, DATA_ZERO);
        set_ev(6, 1'b1);
        irq(1'b1);
        rd(REG_SRC_FLAGS);
        chk(rv, 16'h0040, "flags");
        set_ev(6, 1'b0);
        $display("test events done");
        // Remote fault on every route, then released by its falling edge.
        wr(REG_IRQ_MASK, 16'h0020);
        set_ev(5, 1'b1);
        for (int r = 0; r < 4; r++) begin
            irq_route_sel = 2'(r);
            irq(1'b0);
            chk({13'h0, irq_tx_error_pin_n, irq_ind1_pin_n, irq_ind2_pin_n},
                {13'h0, 1'(r == 1 || r == 2), 1'(r != 1), 1'(r != 2)}, "pins");
        end
        irq_route_sel = ROUTE_TX_ERROR_PIN;
        set_ev(5, 1'b0);
        irq(1'b1);
        wr(REG_IRQ_MASK, 16'h0002);
        set_ev(1, 1'b1);
        irq(1'b0);
        an_restart = 1'b1;
        @(posedge mclk);
        #1;
        an_restart = 1'b0;
        irq(1'b1);
        set_ev(1, 1'b0);
        // Falling edges and link loss release flags with no read at all.
        wr(REG_IRQ_MASK, 16'h0144);
        set_ev(6, 1'b1);
        irq(1'b0);
        set_ev(6, 1'b0);
        irq(1'b1);
        set_ev(8, 1'b1);
        irq(1'b0);
        set_ev(8, 1'b0);
        irq(1'b1);
        set_ev(2, 1'b1);
        irq(1'b0);
        set_ev(4, 1'b1);
        irq(1'b1);
        set_ev(2, 1'b0);
        set_ev(4, 1'b0);
        rd(REG_SRC_FLAGS);
        chk(rv, 16'h0010, "flags");
        $display("test routes done");
        // Alternate mode: reads and falling edges keep the flag.
        alt_irq_mode_sel = 1'b1;
        wr(REG_IRQ_MASK, 16'h0040);
        set_ev(6, 1'b1);
        rd(REG_SRC_FLAGS);
        wr(REG_SRC_FLAGS, 16'h0040);
        irq(1'b0);
        set_ev(6, 1'b0);
        rd(REG_SRC_FLAGS);
        chk(rv, 16'h0040, "alt");
        wr(REG_SRC_FLAGS, 16'h0040);
        irq(1'b1);
        set_ev(6, 1'b1);
        irq(1'b0);
        wr(REG_IRQ_MASK, DATA_ZERO);
        irq(1'b1);
        $display("test alternate done");
        close_out();
    end
endmodule : peiu_phy_event_irq_tb
`default_nettype wire
